// ==== logic/clk_switch_pkg.sv ====
// shared constants and types for the glitch-free clock switchover mux
package clk_switch_pkg;
    // ==========================================================
    // timing
    localparam int REF_PERIOD_NS = 10;
    // an input with no edge for this long counts as stuck
    localparam int STUCK_TIME_NS = 200;
    localparam int STUCK_CYCLES = (STUCK_TIME_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
    // internal power-on delay before the switch logic starts
    localparam int POR_TIME_NS = 100;
    localparam int POR_CYCLES = (POR_TIME_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
    localparam int IDLE_W = 8;
    localparam int POR_W = 6;

    // ==========================================================
    // switchover stage lengths, in input clock pulses
    localparam logic [3:0] OLD_PULSES = 4'h3;
    localparam logic [3:0] HIGH_PULSES = 4'h3;
    localparam logic [3:0] LOW_PULSES = 4'h3;
    localparam logic [4:0] SWITCH_MAX_PULSES = 5'h11;

    // ==========================================================
    // switchover states
    typedef enum logic [2:0] {
        ST_POR = 3'b100,
        ST_FOLLOW = 3'b000,
        ST_OLD = 3'b001,
        ST_HIGH = 3'b010,
        ST_LOW = 3'b011
    } state_t;
endpackage : clk_switch_pkg

// ==== logic/clock_input_sampler.sv ====
// synchroniser, edge finder and stuck detector for one clock input
`timescale 1ns/1ps
module clock_input_sampler (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // raw input and its amplitude flag
    input wire logic raw_clock,
    input wire logic raw_valid,
    // sampled view
    clock_tap_if.source tap
);
    logic [2:0] clk_pipe;
    logic [2:0] next_clk_pipe;
    logic [1:0] valid_pipe;
    logic [1:0] next_valid_pipe;
    logic [clk_switch_pkg::IDLE_W-1:0] idle;
    logic [clk_switch_pkg::IDLE_W-1:0] next_idle;
    localparam logic [clk_switch_pkg::IDLE_W-1:0] IDLE_MAX =
        clk_switch_pkg::IDLE_W'(clk_switch_pkg::STUCK_CYCLES);

    // ==========================================================
    // two flops guard against metastability; stage 2 is the first one read
    always_comb begin
        next_clk_pipe = {clk_pipe[1:0], raw_clock};
        next_valid_pipe = {valid_pipe[0], raw_valid};
        // idle counter restarts on any edge, saturates at the stuck mark
        if (clk_pipe[1] != clk_pipe[2]) begin
            next_idle = '0;
        end else if (idle != IDLE_MAX) begin
            next_idle = idle + 1'b1;
        end else begin
            next_idle = idle;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            clk_pipe <= 3'h0;
            valid_pipe <= 2'h0;
            idle <= '0;
        end else begin
            clk_pipe <= next_clk_pipe;
            valid_pipe <= next_valid_pipe;
            idle <= next_idle;
        end
    end

    // edges are one-cycle pulses; level is stage 2 so it matches the edges
    assign tap.level = clk_pipe[1];
    assign tap.rise = clk_pipe[1] & ~clk_pipe[2];
    assign tap.fall = ~clk_pipe[1] & clk_pipe[2];
    assign tap.stuck = (idle == IDLE_MAX);
    assign tap.valid = valid_pipe[1];
endmodule : clock_input_sampler

// ==== logic/clock_switchover_mux.sv ====
// glitch-free two-input clock switchover mux with fail-safe hold
//
// How it works
// - switchover completes within 17 input clock cycles
// - both inputs handled identically, either may be primary
// - strap high: plain immediate two-input mux
// - lost amplitude: output frozen at last level, except in the old-clock stage
// - running old clock: follow old for pulses
// - then hold low some new pulses, pass new
// - old stuck high: hold high for new pulses
// - then low for new falling edges, pass new
// - select and clocks synchronised against metastability
// - old stuck low: low for new falls
// - extended cycle halves exceed half new period
// - internal power-on delay sets known state
`timescale 1ns/1ps
module clock_switchover_mux (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // clock inputs and their amplitude flags
    input wire logic first_clock_input,
    input wire logic second_clock_input,
    input wire logic first_clock_valid,
    input wire logic second_clock_valid,
    // control pins
    input wire logic select,
    input wire logic startup_delay_strap,
    // output
    output logic clock_out,
    output logic switching
);
    clock_tap_if tap [2] ();
    logic [1:0] raw_clk;
    logic [1:0] raw_valid;
    logic [1:0] lvl;
    logic [1:0] rise;
    logic [1:0] fall;
    logic [1:0] stuck;
    logic [1:0] valid;
    logic [1:0] sel_pipe;
    logic [1:0] strap_pipe;
    logic sel_s;
    logic strap_s;

    assign raw_clk = {second_clock_input, first_clock_input};
    assign raw_valid = {second_clock_valid, first_clock_valid};

    // ==========================================================
    // one identical sampler per input keeps the two paths symmetric
    for (genvar i = 0; i < 2; i++) begin : g_input
        clock_input_sampler u_sampler (
            .ref_clk(ref_clk),
            .arst_n(arst_n),
            .raw_clock(raw_clk[i]),
            .raw_valid(raw_valid[i]),
            .tap(tap[i])
        );
        assign lvl[i] = tap[i].level;
        assign rise[i] = tap[i].rise;
        assign fall[i] = tap[i].fall;
        assign stuck[i] = tap[i].stuck;
        assign valid[i] = tap[i].valid;
    end

    // ==========================================================
    // select and strap are asynchronous pins
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sel_pipe <= 2'h0;
            strap_pipe <= 2'h0;
        end else begin
            sel_pipe <= {sel_pipe[0], select};
            strap_pipe <= {strap_pipe[0], startup_delay_strap};
        end
    end
    assign sel_s = sel_pipe[1];
    assign strap_s = strap_pipe[1];

    // ==========================================================
    // switchover state machine
    clk_switch_pkg::state_t state;
    clk_switch_pkg::state_t next_state;
    logic active;
    logic next_active;
    logic [3:0] count;
    logic [3:0] next_count;
    logic out_q;
    logic next_out;
    logic [clk_switch_pkg::POR_W-1:0] por_count;
    logic [clk_switch_pkg::POR_W-1:0] next_por_count;
    logic newc;
    localparam logic [clk_switch_pkg::POR_W-1:0] POR_DONE =
        clk_switch_pkg::POR_W'(clk_switch_pkg::POR_CYCLES);

    assign newc = ~active;

    // stage counters count edges of the sampled clocks, not ref_clk cycles
    always_comb begin
        next_state = state;
        next_active = active;
        next_count = count;
        next_out = out_q;
        next_por_count = por_count;
        case (state)
            clk_switch_pkg::ST_POR: begin
                next_out = 1'b0;
                if (por_count != POR_DONE) begin
                    next_por_count = por_count + 1'b1;
                end else begin
                    next_state = clk_switch_pkg::ST_FOLLOW;
                    next_active = sel_s;
                end
            end
            clk_switch_pkg::ST_FOLLOW: begin
                next_count = 4'h0;
                if (strap_s) begin
                    // no protection: the mux follows select at once
                    next_active = sel_s;
                    next_out = valid[sel_s] ? lvl[sel_s] : out_q;
                end else if (sel_s != active) begin
                    if (stuck[active] && lvl[active]) begin
                        next_state = clk_switch_pkg::ST_HIGH;
                        next_out = 1'b1;
                    end else if (stuck[active]) begin
                        next_state = clk_switch_pkg::ST_LOW;
                        next_out = 1'b0;
                    end else begin
                        next_state = clk_switch_pkg::ST_OLD;
                        next_out = lvl[active];
                    end
                end else begin
                    // a dead input would chatter; hold the last good level
                    next_out = valid[active] ? lvl[active] : out_q;
                end
            end
            clk_switch_pkg::ST_OLD: begin
                next_out = lvl[active];
                if (strap_s) begin
                    next_state = clk_switch_pkg::ST_FOLLOW;
                end else if (stuck[active]) begin
                    next_state = lvl[active] ? clk_switch_pkg::ST_HIGH
                                             : clk_switch_pkg::ST_LOW;
                    next_out = lvl[active];
                    next_count = 4'h0;
                end else if (fall[active]) begin
                    if (count == clk_switch_pkg::OLD_PULSES - 4'h1) begin
                        // leave on an old falling edge so the low half is long
                        next_state = clk_switch_pkg::ST_LOW;
                        next_out = 1'b0;
                        next_count = 4'h0;
                    end else begin
                        next_count = count + 4'h1;
                    end
                end
            end
            clk_switch_pkg::ST_HIGH: begin
                next_out = 1'b1;
                if (strap_s) begin
                    next_state = clk_switch_pkg::ST_FOLLOW;
                end else if (rise[newc]) begin
                    if (count == clk_switch_pkg::HIGH_PULSES - 4'h1) begin
                        next_state = clk_switch_pkg::ST_LOW;
                        next_out = 1'b0;
                        next_count = 4'h0;
                    end else begin
                        next_count = count + 4'h1;
                    end
                end
            end
            clk_switch_pkg::ST_LOW: begin
                next_out = 1'b0;
                if (strap_s) begin
                    next_state = clk_switch_pkg::ST_FOLLOW;
                end else if (fall[newc]) begin
                    if (count == clk_switch_pkg::LOW_PULSES - 4'h1) begin
                        // hand over just after a new falling edge: high half is whole
                        next_state = clk_switch_pkg::ST_FOLLOW;
                        next_active = newc;
                        next_count = 4'h0;
                    end else begin
                        next_count = count + 4'h1;
                    end
                end
            end
            default: begin
                next_state = clk_switch_pkg::ST_POR;
                next_out = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= clk_switch_pkg::ST_POR;
            active <= 1'b0;
            count <= 4'h0;
            out_q <= 1'b0;
            por_count <= '0;
        end else begin
            state <= next_state;
            active <= next_active;
            count <= next_count;
            out_q <= next_out;
            por_count <= next_por_count;
        end
    end

    assign clock_out = out_q;
    assign switching = (state == clk_switch_pkg::ST_OLD) ||
                       (state == clk_switch_pkg::ST_HIGH) ||
                       (state == clk_switch_pkg::ST_LOW);

    // ==========================================================
    // helper: new-clock falls seen during one switchover
    logic [4:0] seq_falls;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            seq_falls <= 5'h00;
        end else if (!switching) begin
            seq_falls <= 5'h00;
        end else if (fall[newc] && seq_falls != 5'h1f) begin
            seq_falls <= seq_falls + 5'h01;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    chk_switch_bound: assert property (seq_falls <= clk_switch_pkg::SWITCH_MAX_PULSES)
        else $error("switchover took too many new clock pulses");
    chk_strap_mux: assert property (state == clk_switch_pkg::ST_FOLLOW && strap_s
        |=> active == $past(sel_s) && !switching)
        else $error("strap mode did not switch at once");
    chk_fsafe_hold: assert property (state == clk_switch_pkg::ST_FOLLOW && !strap_s
        && sel_s == active && !valid[active] |=> $stable(clock_out))
        else $error("output moved while selected input invalid");
    chk_old_follow: assert property (state == clk_switch_pkg::ST_OLD
        && next_state == clk_switch_pkg::ST_OLD |=> clock_out == $past(lvl[active]))
        else $error("old clock stage did not follow old clock");
    chk_low_hold: assert property (state == clk_switch_pkg::ST_LOW |-> !clock_out)
        else $error("output high during low hold");
    chk_high_hold: assert property (state == clk_switch_pkg::ST_HIGH |-> clock_out)
        else $error("output low during high hold");
    chk_high_to_low: assert property (state == clk_switch_pkg::ST_HIGH
        && next_state == clk_switch_pkg::ST_LOW |=> state == clk_switch_pkg::ST_LOW
        ##1 !clock_out)
        else $error("high hold did not end low");
    chk_stuck_low: assert property (state == clk_switch_pkg::ST_FOLLOW && !strap_s
        && sel_s != active && stuck[active] && !lvl[active]
        |=> state == clk_switch_pkg::ST_LOW && !clock_out)
        else $error("stuck low switch did not hold low");
    chk_handover: assert property (state == clk_switch_pkg::ST_LOW
        && next_state == clk_switch_pkg::ST_FOLLOW && !strap_s
        |=> active != $past(active) && !clock_out && !lvl[active])
        else $error("handover not after a new falling edge");
    chk_por_state: assert property (state == clk_switch_pkg::ST_POR |-> !clock_out)
        else $error("output active before power-on delay ended");

    cov_normal: cover property (state == clk_switch_pkg::ST_OLD
        ##1 state == clk_switch_pkg::ST_LOW);
    cov_stuck_high: cover property (state == clk_switch_pkg::ST_HIGH
        ##1 state == clk_switch_pkg::ST_LOW);
    cov_stuck_low: cover property (state == clk_switch_pkg::ST_FOLLOW
        ##1 state == clk_switch_pkg::ST_LOW);
    cov_strap: cover property (strap_s && $changed(active));
endmodule : clock_switchover_mux

// ==== logic/clock_tap_if.sv ====
// sampled view of one clock input, passed from sampler to switch logic
`timescale 1ns/1ps
interface clock_tap_if;
    logic level;
    logic rise;
    logic fall;
    logic stuck;
    logic valid;
    modport source (output level, output rise, output fall, output stuck, output valid);
    modport sink (input level, input rise, input fall, input stuck, input valid);
endinterface : clock_tap_if

// ==== verification/clock_source_model.sv ====
// behavioural model of the two redundant clock sources at the mux inputs
`timescale 1ns/1ps
module clock_source_model (
    // per-source half periods in ns, and mode: 0 run, 1 stuck low, 2 stuck high
    input wire logic [7:0] half_a,
    input wire logic [7:0] half_b,
    input wire logic [1:0] mode_a,
    input wire logic [1:0] mode_b,
    // source clocks
    output logic clk_a,
    output logic clk_b
);
    // ==========================================================
    // oscillators
    initial clk_a = 1'b0;
    initial clk_b = 1'b0;
    // each source is free running; its period is chosen by the bench within 1.5:1
    always begin
        #(half_a);
        clk_a = (mode_a == 2'h0) ? ~clk_a : mode_a[1];
    end
    // a stuck source keeps no edge at all, so the mux sees a true dc level
    always begin
        #(half_b);
        clk_b = (mode_b == 2'h0) ? ~clk_b : mode_b[1];
    end
endmodule : clock_source_model

// ==== verification/tb.sv ====
// self-checking testbench for the clock switchover mux
`timescale 1ns/1ps
module tb;
    // ==========================================================
    // signals
    logic ref_clk = 1'b0, arst_n = 1'b0, sel = 1'b0, strap = 1'b0;
    logic v0 = 1'b1, v1 = 1'b1, clk0, old_selected_clock, clock_out, switching, last = 1'b0;
    logic [1:0] mode0 = 2'h0, mode1 = 2'h0;
    logic [7:0] half0 = 8'h32, half1 = 8'h2d;
    logic [3:0] h0 = 4'h0, h1 = 4'h0;
    logic runt_en = 1'b0, in_sw = 1'b0;
    int miscompares = 0, tests_run = 0, ph = 0, max_hi = 0, max_lo = 0, rises = 0;

    always #5 ref_clk = ~ref_clk;

    clock_source_model clock_source_model_inst (.half_a(half0), .half_b(half1),
        .mode_a(mode0), .mode_b(mode1), .clk_a(clk0), .clk_b(old_selected_clock));
    clock_switchover_mux clock_switchover_mux_inst (.ref_clk(ref_clk), .arst_n(arst_n),
        .first_clock_input(clk0), .second_clock_input(old_selected_clock), .first_clock_valid(v0),
        .second_clock_valid(v1), .select(sel), .startup_delay_strap(strap),
        .clock_out(clock_out), .switching(switching));

    // ==========================================================
    // helpers
    task check(input logic seen, input logic exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: saw %b, expected %b", $time, seen, exp);
        end
    endtask : check

    task results;
        if (miscompares == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results

    // worst switchover length in ref cycles: 17 cycles of the slower source
    function int sw_limit(input logic [7:0] ha, input logic [7:0] hb);
        return (17 * 2 * ((ha > hb) ? ha : hb) + 9) / 10;
    endfunction : sw_limit

    // one period of the given source, in ref cycles, rounded down
    function int period_cyc(input logic [7:0] h);
        return (2 * h) / 10;
    endfunction : period_cyc

    // input level history as the mux samples it, newest in bit 0
    always @(posedge ref_clk) begin
        h0 <= {h0[2:0], clk0};
        h1 <= {h1[2:0], old_selected_clock};
    end

    // phase monitor: no runt phase, and stage lengths seen while switching
    // a phase counts as a switchover phase if any cycle of it was switching,
    // since the final low stage only ends after the handover
    always @(negedge ref_clk) begin
        if (switching === 1'b1) in_sw = 1'b1;
        if (clock_out !== last) begin
            if (runt_en) check(ph >= 3, 1'b1);
            if (in_sw && last === 1'b1 && ph > max_hi) max_hi = ph;
            if (in_sw && last === 1'b0 && ph > max_lo) max_lo = ph;
            if (switching === 1'b1 && clock_out === 1'b1) rises++;
            ph = 0;
            last = clock_out;
            in_sw = (switching === 1'b1);
        end else begin
            ph++;
        end
    end

    // output tracks the selected input with the two-flop sampling lag
    task check_follow(input int n);
        logic [3:0] h;
        repeat (n) begin
            @(negedge ref_clk);
            h = sel ? h1 : h0;
            check(clock_out === h[1] || clock_out === h[2] || clock_out === h[3], 1'b1);
        end
    endtask : check_follow

    // flip select and wait, bounded, for the protected switchover to end
    task do_switch(input int bound);
        int n;
        sel = ~sel;
        max_hi = 0;
        max_lo = 0;
        rises = 0;
        repeat (4) @(negedge ref_clk);
        check(switching, 1'b1);
        n = 0;
        while (switching === 1'b1 && n < bound + 20) begin
            @(negedge ref_clk);
            n++;
        end
        check(n <= bound, 1'b1);
        if (n >= bound + 20) begin
            miscompares++;
            results();
        end
        // let the last low stage close on a new rise so its length is measured
        repeat (16) @(negedge ref_clk);
    endtask : do_switch

    // ==========================================================
    // main sequence
    initial begin
        logic v;
        void'($urandom(32'h003b));
        repeat (16) @(negedge ref_clk);
        check(clock_out, 1'b0);
        check(switching, 1'b0);
        arst_n = 1'b1;
        // power-on delay keeps the output quiet though the inputs toggle
        repeat (10) begin
            @(negedge ref_clk);
            check(clock_out, 1'b0);
        end
        repeat (10) @(negedge ref_clk);
        runt_en = 1'b1;
        check_follow(60);
        // running clocks both ways, random periods within 1.5:1
        for (int i = 0; i < 6; i++) begin
            half0 = 8'd40 + 8'($urandom % 21);
            half1 = 8'd40 + 8'($urandom % 21);
            repeat (30) @(negedge ref_clk);
            do_switch(sw_limit(half0, half1));
            check(rises >= 1, 1'b1);
            check(max_lo >= period_cyc(sel ? half1 : half0), 1'b1);
            check_follow(60);
        end
        // old source dead: stuck high first, then stuck low
        for (int m = 2; m >= 1; m--) begin
            if (sel) mode1 = 2'(m); else mode0 = 2'(m);
            // margin past the stuck timeout plus one slow half period
            repeat (40) @(negedge ref_clk);
            check(clock_out, m == 2);
            do_switch(sw_limit(half0, half1));
            if (m == 2) check(max_hi >= period_cyc(sel ? half1 : half0), 1'b1);
            check(max_lo >= period_cyc(sel ? half1 : half0), 1'b1);
            check_follow(60);
            mode0 = 2'h0;
            mode1 = 2'h0;
            repeat (30) @(negedge ref_clk);
        end
        // amplitude loss on the unselected input changes nothing
        if (sel) v0 = 1'b0; else v1 = 1'b0;
        check_follow(40);
        v0 = 1'b1;
        v1 = 1'b1;
        // amplitude loss on the selected input freezes the output
        if (sel) v1 = 1'b0; else v0 = 1'b0;
        repeat (4) @(negedge ref_clk);
        v = clock_out;
        repeat (40) begin
            @(negedge ref_clk);
            check(clock_out, v);
        end
        // leaving the hold may cut a phase short, which no rule forbids
        runt_en = 1'b0;
        v0 = 1'b1;
        v1 = 1'b1;
        repeat (10) @(negedge ref_clk);
        // strap high: plain mux, runts are allowed here
        runt_en = 1'b0;
        strap = 1'b1;
        repeat (6) @(negedge ref_clk);
        sel = ~sel;
        repeat (30) begin
            @(negedge ref_clk);
            check(switching, 1'b0);
        end
        check_follow(40);
        results();
    end
endmodule : tb
